// >>> rtl/sesl_pkg.sv
// constants shared by the standard event status logic
package sesl_pkg;

  // ==========================================================================
  // widths
  localparam int SESL_W = 8;

  // ==========================================================================
  // standard event flag positions
  localparam int SESL_PON_BIT = 7;
  localparam int SESL_UNUSED_HI_BIT = 6;
  localparam int SESL_CME_BIT = 5;
  localparam int SESL_EXE_BIT = 4;
  localparam int SESL_DDE_BIT = 3;
  localparam int SESL_QYE_BIT = 2;
  localparam int SESL_UNUSED_LO_BIT = 1;
  localparam int SESL_OPC_BIT = 0;

  // bits that may ever be set in the event flags
  localparam logic [7:0] SESL_EVT_USED_MASK = 8'hbd;

  // ==========================================================================
  // status byte and service request enable positions
  localparam int SESL_STB_RAMP_BIT = 7;
  localparam int SESL_STB_RQS_BIT = 6;
  localparam int SESL_STB_ESB_BIT = 5;
  localparam int SESL_STB_ERR_BIT = 4;
  localparam int SESL_STB_ALARM_BIT = 3;
  localparam int SESL_STB_NEW_BIT = 0;

  // latched status byte sources (ramp, error, alarm, new data)
  localparam logic [7:0] SESL_STB_LATCH_MASK = 8'h99;
  // status byte bits that may raise a request (all used bits but the request bit)
  localparam logic [7:0] SESL_STB_REQ_MASK = 8'hb9;

  // ==========================================================================
  // values after reset
  localparam logic [7:0] SESL_EVT_RESET = 8'h80;
  localparam logic [7:0] SESL_ESE_RESET = 8'h00;
  localparam logic [7:0] SESL_SRE_RESET = 8'h00;
  localparam logic [7:0] SESL_STB_RESET = 8'h00;
  localparam logic [7:0] SESL_RESP_RESET = 8'h00;

  // ==========================================================================
  // response sources
  typedef enum logic [2:0] {
    SESL_RESP_NONE,
    SESL_RESP_EVT,
    SESL_RESP_ESE,
    SESL_RESP_SRE,
    SESL_RESP_STB,
    SESL_RESP_POLL
  } sesl_resp_t;

  // operation-complete tracker
  typedef enum {
    SESL_OPC_IDLE,
    SESL_OPC_WAIT
  } sesl_opc_state_t;

endpackage : sesl_pkg

// >>> rtl/sesl_evt_if.sv
// carrier between the top and the event flag latch
`timescale 1ns/1ps
interface sesl_evt_if;
  logic [7:0] set_vec;
  logic clear_all;
  logic [7:0] flags;

  modport latch (input set_vec, input clear_all, output flags);
  modport user (output set_vec, output clear_all, input flags);
endinterface : sesl_evt_if

// >>> rtl/sesl_event_reg.sv
// sticky standard event flags, cleared as a whole by a read
`timescale 1ns/1ps
module sesl_event_reg
  import sesl_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // flag carrier
  sesl_evt_if.latch evt
);

  logic [7:0] flags_r;
  logic [7:0] flags_nxt;

  // ==========================================================================
  // next value
  always_comb begin
    flags_nxt = flags_r;
    if (evt.clear_all) begin
      flags_nxt = 8'h00;
    end
    // a set in the clearing cycle survives
    flags_nxt = (flags_nxt | evt.set_vec) & SESL_EVT_USED_MASK;
  end

  // ==========================================================================
  // register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      flags_r <= SESL_EVT_RESET;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  assign evt.flags = flags_r;

endmodule : sesl_event_reg

// >>> rtl/sesl_top.sv
// standard event status logic with status byte summary and service request
//
// Contract
// - set power-on flag, bit 7, on every off-to-on transition.
// - bit 6 (and bit 1) of the event flags never set.
// - event reports request service only if enabled and request enable bit 5 set.
// - enable write sets each report whose written bit is one.
// - enable query returns current enable register contents.
// - event query returns flags, then clears all of them.
// - command error sets bit 5, held until next event read.
// - execution error sets bit 4.
// - device-dependent error sets bit 3; cause read through device queries.
// - lost response data due to full output queue sets bit 2.
// - after operation-complete command, set bit 0 when pending work ends.
// - status byte bit 5 shows any enabled event flag set.
// - pull request line low only if request enable bit 6 and enabled bit set.
`timescale 1ns/1ps
module sesl_top
  import sesl_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // supply-good pin, asynchronous
  input wire logic power_good,
  // decoded common commands from the parser, one-cycle pulses
  input wire logic ese_write,
  input wire logic [7:0] ese_write_data,
  input wire logic ese_query,
  input wire logic esr_query,
  input wire logic sre_write,
  input wire logic [7:0] sre_write_data,
  input wire logic sre_query,
  input wire logic stb_query,
  input wire logic serial_poll,
  input wire logic opc_command,
  // event sources, one-cycle pulses
  input wire logic cmd_error,
  input wire logic exec_error,
  input wire logic dev_error,
  input wire logic query_lost,
  // pending operation level
  input wire logic ops_pending,
  // other status byte sources, one-cycle pulses
  input wire logic ramp_done,
  input wire logic inst_error,
  input wire logic alarm,
  input wire logic new_data,
  // response to a query or poll
  output logic resp_valid,
  output logic [7:0] resp_data,
  // service request line, open drain
  output logic srq_o,
  output logic srq_oe,
  // visible state
  output logic [7:0] event_flags,
  output logic [7:0] status_byte
);

  // ==========================================================================
  // reset release
  logic rst_s1_r;
  logic rst_s2_r;
  logic rst_n_int;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end

  assign rst_n_int = rst_s2_r;

  // ==========================================================================
  // supply pin synchroniser and rising edge
  logic pwr_s1_r;
  logic pwr_s2_r;
  logic pwr_d_r;
  logic pwr_rise;

  always_ff @(posedge clk_sys or negedge rst_n_int) begin
    if (!rst_n_int) begin
      pwr_s1_r <= 1'b0;
      pwr_s2_r <= 1'b0;
      pwr_d_r <= 1'b0;
    end else begin
      pwr_s1_r <= power_good;
      pwr_s2_r <= pwr_s1_r;
      pwr_d_r <= pwr_s2_r;
    end
  end

  // the reset value already holds the flag for the first power-up
  assign pwr_rise = pwr_s2_r & ~pwr_d_r;

  // ==========================================================================
  // operation-complete tracker
  sesl_opc_state_t opc_state_r;
  sesl_opc_state_t opc_state_nxt;
  logic opc_done;

  always_comb begin
    opc_state_nxt = opc_state_r;
    opc_done = 1'b0;
    case (opc_state_r)
      SESL_OPC_IDLE: begin
        if (opc_command) begin
          opc_state_nxt = SESL_OPC_WAIT;
        end
      end
      SESL_OPC_WAIT: begin
        // a repeat command while waiting just keeps waiting
        if (!ops_pending && !opc_command) begin
          opc_done = 1'b1;
          opc_state_nxt = SESL_OPC_IDLE;
        end
      end
      default: begin
        opc_state_nxt = SESL_OPC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n_int) begin
    if (!rst_n_int) begin
      opc_state_r <= SESL_OPC_IDLE;
    end else begin
      opc_state_r <= opc_state_nxt;
    end
  end

  // ==========================================================================
  // event flags
  sesl_evt_if evt_bus ();
  logic [7:0] set_vec;

  always_comb begin
    set_vec = 8'h00;
    set_vec[SESL_PON_BIT] = pwr_rise;
    set_vec[SESL_CME_BIT] = cmd_error;
    set_vec[SESL_EXE_BIT] = exec_error;
    set_vec[SESL_DDE_BIT] = dev_error;
    set_vec[SESL_QYE_BIT] = query_lost;
    set_vec[SESL_OPC_BIT] = opc_done;
  end

  assign evt_bus.set_vec = set_vec;
  assign evt_bus.clear_all = esr_query;

  sesl_event_reg u_event_reg (
    .clk_sys (clk_sys),
    .rst_n (rst_n_int),
    .evt (evt_bus.latch)
  );

  // ==========================================================================
  // enable registers
  logic [7:0] ese_r;
  logic [7:0] ese_nxt;
  logic [7:0] sre_r;
  logic [7:0] sre_nxt;

  always_comb begin
    ese_nxt = ese_r;
    sre_nxt = sre_r;
    if (ese_write) begin
      ese_nxt = ese_write_data;
    end
    if (sre_write) begin
      sre_nxt = sre_write_data;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n_int) begin
    if (!rst_n_int) begin
      ese_r <= SESL_ESE_RESET;
      sre_r <= SESL_SRE_RESET;
    end else begin
      ese_r <= ese_nxt;
      sre_r <= sre_nxt;
    end
  end

  // ==========================================================================
  // status byte
  logic [7:0] stb_latch_r;
  logic [7:0] stb_latch_nxt;
  logic [7:0] stb_src;
  logic esb;
  logic rqs;
  logic [7:0] stb_now;

  always_comb begin
    stb_src = 8'h00;
    stb_src[SESL_STB_RAMP_BIT] = ramp_done;
    stb_src[SESL_STB_ERR_BIT] = inst_error;
    stb_src[SESL_STB_ALARM_BIT] = alarm;
    stb_src[SESL_STB_NEW_BIT] = new_data;
    stb_latch_nxt = stb_latch_r;
    // a serial poll clears the latched bits; a new report still wins
    if (serial_poll) begin
      stb_latch_nxt = 8'h00;
    end
    stb_latch_nxt = (stb_latch_nxt | stb_src) & SESL_STB_LATCH_MASK;
  end

  always_ff @(posedge clk_sys or negedge rst_n_int) begin
    if (!rst_n_int) begin
      stb_latch_r <= SESL_STB_RESET;
    end else begin
      stb_latch_r <= stb_latch_nxt;
    end
  end

  // summary follows the flags and the enable register, so an event read or an enable write can drop it
  assign esb = |(evt_bus.flags & ese_r);

  always_comb begin
    stb_now = stb_latch_r;
    stb_now[SESL_STB_ESB_BIT] = esb;
    // events reach the request only through enable bit 5
    rqs = |(stb_now & sre_r & SESL_STB_REQ_MASK);
    stb_now[SESL_STB_RQS_BIT] = rqs;
  end

  // ==========================================================================
  // service request line
  logic srq_oe_r;
  logic srq_oe_nxt;
  logic srq_o_r;

  always_comb begin
    srq_oe_nxt = sre_r[SESL_STB_RQS_BIT] & rqs;
  end

  always_ff @(posedge clk_sys or negedge rst_n_int) begin
    if (!rst_n_int) begin
      srq_oe_r <= 1'b0;
      srq_o_r <= 1'b0;
    end else begin
      srq_oe_r <= srq_oe_nxt;
      // open drain: only ever drives low
      srq_o_r <= 1'b0;
    end
  end

  // ==========================================================================
  // query responses
  // only one query is handled per cycle; the parser never issues two
  logic resp_valid_r;
  logic resp_valid_nxt;
  logic [7:0] resp_data_r;
  logic [7:0] resp_data_nxt;
  sesl_resp_t resp_sel;

  always_comb begin
    resp_sel = SESL_RESP_NONE;
    if (esr_query) begin
      resp_sel = SESL_RESP_EVT;
    end else if (ese_query) begin
      resp_sel = SESL_RESP_ESE;
    end else if (sre_query) begin
      resp_sel = SESL_RESP_SRE;
    end else if (stb_query) begin
      resp_sel = SESL_RESP_STB;
    end else if (serial_poll) begin
      resp_sel = SESL_RESP_POLL;
    end
  end

  always_comb begin
    resp_valid_nxt = 1'b1;
    resp_data_nxt = resp_data_r;
    case (resp_sel)
      SESL_RESP_EVT: begin
        resp_data_nxt = evt_bus.flags;
      end
      SESL_RESP_ESE: begin
        resp_data_nxt = ese_r;
      end
      SESL_RESP_SRE: begin
        resp_data_nxt = sre_r;
      end
      SESL_RESP_STB, SESL_RESP_POLL: begin
        resp_data_nxt = stb_now;
      end
      default: begin
        resp_valid_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n_int) begin
    if (!rst_n_int) begin
      resp_valid_r <= 1'b0;
      resp_data_r <= SESL_RESP_RESET;
    end else begin
      resp_valid_r <= resp_valid_nxt;
      resp_data_r <= resp_data_nxt;
    end
  end

  // ==========================================================================
  // visible state
  logic [7:0] event_flags_r;
  logic [7:0] status_byte_r;

  always_ff @(posedge clk_sys or negedge rst_n_int) begin
    if (!rst_n_int) begin
      event_flags_r <= SESL_EVT_RESET;
      status_byte_r <= SESL_STB_RESET;
    end else begin
      event_flags_r <= evt_bus.flags;
      status_byte_r <= stb_now;
    end
  end

  assign resp_valid = resp_valid_r;
  assign resp_data = resp_data_r;
  assign srq_o = srq_o_r;
  assign srq_oe = srq_oe_r;
  assign event_flags = event_flags_r;
  assign status_byte = status_byte_r;

endmodule : sesl_top

// >>> tb/sesl_host_model.sv
// bus controller model: pulls up the request line and answers it with one poll
`timescale 1ns/1ps
module sesl_host_model #(
  parameter int POLL_DELAY = 3
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // request line
  input wire logic srq_oe,
  input wire logic srq_o,
  output logic srq_n,
  // poll control
  input wire logic poll_en,
  output logic serial_poll
);
  int wait_cnt = 0;
  logic done = 1'b0;
  // pull-up: the line reads high whenever the device lets go
  // while enabled the line shows what the device drives, so a wrong drive level shows up
  assign srq_n = srq_oe ? srq_o : 1'b1;
  initial serial_poll = 1'b0;
  // a controller is never instant, so it lets the request wait a while
  always @(negedge clk_sys) begin
    serial_poll <= 1'b0;
    if (!reset_n || !poll_en) begin
      wait_cnt <= 0;
      done <= 1'b0;
    end else if (!srq_n && !done) begin
      if (wait_cnt == POLL_DELAY) begin
        serial_poll <= 1'b1;
        done <= 1'b1;
      end
      wait_cnt <= wait_cnt + 1;
    end
  end
endmodule : sesl_host_model

// >>> tb/sesl_chk.sv
// port assertions for the standard event status logic
`timescale 1ns/1ps
module sesl_chk (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // commands and events
  input wire logic esr_query, ese_query, ese_write, opc_command, ops_pending,
  input wire logic cmd_error, exec_error, dev_error, query_lost,
  input wire logic [7:0] ese_write_data,
  // answers and state
  input wire logic resp_valid,
  input wire logic [7:0] resp_data, event_flags, status_byte
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  logic any_evt;
  assign any_evt = cmd_error | exec_error | dev_error | query_lost;
  // ==========================================================================
  // event flags
  property p_unused; event_flags[6] == 1'b0 && event_flags[1] == 1'b0; endproperty
  a_unused: assert property (p_unused) else $error("unused flag set");
  property p_cme; cmd_error |-> ##2 event_flags[5]; endproperty
  a_cme: assert property (p_cme) else $error("command flag missing");
  property p_exe; exec_error |-> ##2 event_flags[4]; endproperty
  a_exe: assert property (p_exe) else $error("execution flag missing");
  property p_dde; dev_error |-> ##2 event_flags[3]; endproperty
  a_dde: assert property (p_dde) else $error("device flag missing");
  property p_qye; query_lost |-> ##2 event_flags[2]; endproperty
  a_qye: assert property (p_qye) else $error("query flag missing");
  // set wins over clear, so only a quiet query cycle promises zeros
  property p_clr; esr_query && !any_evt |-> ##2 event_flags[5:2] == 4'h0; endproperty
  a_clr: assert property (p_clr) else $error("flags not cleared");
  property p_opc;
    opc_command ##1 (!ops_pending && !opc_command)[*3] |-> event_flags[0];
  endproperty
  a_opc: assert property (p_opc) else $error("completion flag missing");
  // ==========================================================================
  // enable register and summary
  property p_ese;
    ese_write ##1 !ese_write ##1 (ese_query && !esr_query)
      |=> resp_valid && resp_data == $past(ese_write_data, 3);
  endproperty
  a_ese: assert property (p_ese) else $error("enable readback wrong");
  property p_esb;
    $rose(status_byte[5]) |-> event_flags != 8'h00 || $past(event_flags) != 8'h00;
  endproperty
  a_esb: assert property (p_esb) else $error("summary without flag");
  c_ese: cover property (ese_write ##2 ese_query);
  c_opc: cover property (opc_command ##[1:20] event_flags[0]);
  c_esb: cover property ($rose(status_byte[5]));
endmodule : sesl_chk
bind sesl_top sesl_chk u_sesl_chk (.clk_sys, .reset_n, .esr_query, .ese_query,
  .ese_write, .opc_command, .ops_pending, .cmd_error, .exec_error, .dev_error,
  .query_lost, .ese_write_data, .resp_valid, .resp_data, .event_flags, .status_byte);

// >>> tb/tb_top.sv
// self-checking bench for the standard event status logic
`timescale 1ns/1ps
module tb_top;
  import sesl_pkg::*;
  logic clk_sys = 0, reset_n = 0, power_good = 0, ese_write = 0, ese_query = 0;
  logic esr_query = 0, sre_write = 0, sre_query = 0, stb_query = 0, opc_command = 0;
  logic ops_pending = 0, poll_en = 0;
  logic [3:0] evs = 4'h0, sts = 4'h0;
  logic [7:0] ese_write_data = 8'h00, sre_write_data = 8'h00, d, mon_e;
  logic resp_valid, srq_o, srq_oe, srq_n, serial_poll;
  logic [7:0] resp_data, event_flags, status_byte;
  logic [7:0] exp_q[$];
  logic [7:0] t_ese[3] = '{8'h20, 8'h10, 8'h20};
  logic [7:0] t_sre[3] = '{8'h40, 8'h60, 8'h60};
  logic [7:0] t_stb[3] = '{8'h20, 8'h00, 8'h60};
  logic [7:0] t_src[4] = '{8'h80, 8'h10, 8'h08, 8'h01};
  int error_cnt = 0, comparisons = 0, cycles = 0, seed = 98165;

  sesl_top u_sesl_top (.clk_sys, .reset_n, .power_good, .ese_write, .ese_write_data,
    .ese_query, .esr_query, .sre_write, .sre_write_data, .sre_query, .stb_query,
    .serial_poll, .opc_command, .cmd_error(evs[3]), .exec_error(evs[2]),
    .dev_error(evs[1]), .query_lost(evs[0]), .ops_pending, .ramp_done(sts[3]),
    .inst_error(sts[2]), .alarm(sts[1]), .new_data(sts[0]), .resp_valid, .resp_data,
    .srq_o, .srq_oe, .event_flags, .status_byte);
  sesl_host_model u_sesl_host_model (.clk_sys, .reset_n, .srq_oe, .srq_o, .srq_n,
    .poll_en, .serial_poll);

  initial forever #12.5 clk_sys = ~clk_sys;

  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check8

  task automatic end_of_test();
    $display("error_cnt %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_of_test

  task automatic pulse(ref logic s);
    @(negedge clk_sys) s = 1'b1;
    @(negedge clk_sys) s = 1'b0;
  endtask : pulse

  task automatic ask(ref logic q, input logic [7:0] e);
    exp_q.push_back(e);
    pulse(q);
    repeat (2) @(negedge clk_sys);
  endtask : ask

  // ==========================================================================
  // answer monitor and watchdog
  always @(posedge clk_sys) begin
    cycles++;
    if (resp_valid === 1'b1) begin
      mon_e = exp_q.size() ? exp_q.pop_front() : ~resp_data;
      check8(resp_data, mon_e);
    end
    if (cycles == 5000) begin
      error_cnt++;
      end_of_test();
    end
  end

  // ==========================================================================
  // main sequence
  initial begin
    repeat (20) @(negedge clk_sys);
    reset_n = 1'b1;
    power_good = 1'b1;
    repeat (6) @(negedge clk_sys);
    check8(event_flags, 8'h80);
    ask(esr_query, 8'h80);
    check8(event_flags, 8'h00);
    power_good = 1'b0;
    repeat (4) @(negedge clk_sys);
    power_good = 1'b1;
    repeat (6) @(negedge clk_sys);
    ask(esr_query, 8'h80);
    for (int i = 0; i < 4; i++) begin
      @(negedge clk_sys) evs = 4'h8 >> i;
      @(negedge clk_sys) evs = 4'h0;
      repeat (5) @(negedge clk_sys);
      check8(event_flags, 8'h20 >> i);
      ask(esr_query, 8'h20 >> i);
    end
    for (int k = 0; k < 4; k++) begin
      d = 8'($random(seed));
      ese_write_data = d;
      pulse(ese_write);
      ask(ese_query, d);
      sre_write_data = ~d;
      pulse(sre_write);
      ask(sre_query, ~d);
    end
    for (int p = 1; p >= 0; p--) begin
      ops_pending = p[0];
      pulse(opc_command);
      repeat (4) @(negedge clk_sys);
      check8(event_flags, {7'h0, ~p[0]});
      ops_pending = 1'b0;
      repeat (4) @(negedge clk_sys);
      ask(esr_query, 8'h01);
    end
    for (int k = 0; k < 3; k++) begin
      ese_write_data = t_ese[k];
      pulse(ese_write);
      sre_write_data = t_sre[k];
      pulse(sre_write);
      @(negedge clk_sys) evs = 4'h8;
      @(negedge clk_sys) evs = 4'h0;
      repeat (4) @(negedge clk_sys);
      check8(status_byte, t_stb[k]);
      check8({7'h0, srq_n}, {7'h0, ~t_stb[k][6]});
      ask(stb_query, t_stb[k]);
      if (k == 2) begin
        exp_q.push_back(t_stb[k]);
        poll_en = 1'b1;
        repeat (8) @(negedge clk_sys);
        poll_en = 1'b0;
      end
      ask(esr_query, 8'h20);
      repeat (2) @(negedge clk_sys);
      check8({7'h0, srq_n}, 8'h01);
    end
    // latched status sources: each raises the request, a poll answers and clears it
    sre_write_data = 8'hd9;
    pulse(sre_write);
    for (int j = 0; j < 4; j++) begin
      @(negedge clk_sys) sts = 4'h8 >> j;
      @(negedge clk_sys) sts = 4'h0;
      repeat (4) @(negedge clk_sys);
      check8(status_byte, t_src[j] | 8'h40);
      check8({7'h0, srq_n}, 8'h00);
      exp_q.push_back(t_src[j] | 8'h40);
      poll_en = 1'b1;
      repeat (8) @(negedge clk_sys);
      poll_en = 1'b0;
      repeat (2) @(negedge clk_sys);
      check8(status_byte, 8'h00);
      check8({7'h0, srq_n}, 8'h01);
    end
    check8(8'(exp_q.size()), 8'h00);
    end_of_test();
  end
endmodule : tb_top
